// ### verilog/irq_priority_control_regs.sv
// control and status registers of the vectored interrupt controller
// assumes an apb master on sys_clk and a core that pulses ack, trap entry and return
//
// The register offsets and register access over APB are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - trap control holds nesting disable at bit 15 plus trap enables and flags
// - global control holds external edge polarity and alternate table select
// - one flag per source, set by hardware, cleared only by software
// - one enable bit per source gates its request
// - each source has a 3-bit priority picking one of eight levels
// - sources map in vector order; source 0 at bit 0, priority bits 2:0
// - cpu level low bits sit at status bits 7-5, reset zero, writable
// - the low bits encode the level directly, 111 is level 7
// - level top bit sits in core control bit 3 and is read only
// - top bit reads 1 above level 7, else 0
// - top bit joins low bits into a 4-bit level; set blocks all user requests
// - with nesting disabled the low level bits ignore software writes
// - pending register latches 7-bit vector and 4-bit new level
// - request only when priority strictly exceeds the current cpu level
// - nesting disabled: accepting forces the low level bits to 111
// - polarity bit 1 selects falling edge, 0 rising edge
// - alternate table select 1 uses alternate vectors, 0 the default ones
module irq_priority_control_regs import irq_pkg::*; #(
  parameter int NUM_SRC = 16,
  parameter int NUM_EXT = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // request sources
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic [NUM_EXT-1:0] ext_pin,
  input wire logic [REG_W-1:0] trap_event,
  input wire logic disi_active,
  // core side
  input wire logic core_ack,
  input wire logic core_trap_entry,
  input wire logic core_return,
  input wire logic [LEVEL_W-1:0] restore_level,
  output logic core_req,
  output logic [VEC_W-1:0] core_vector,
  output logic [LEVEL_W-1:0] core_new_level,
  output logic [LEVEL_W-1:0] cpu_level,
  output logic alternate_table_select,
  output logic [2:0] trap_enable,
  // system interrupt
  output logic irq
);
  localparam int NUM_FREG = NUM_SRC / FLAGS_PER_REG;
  localparam int NUM_PREG = NUM_SRC / PRIO_PER_REG;

  if (NUM_SRC % FLAGS_PER_REG != 0 || NUM_SRC > MAX_SRC || NUM_EXT < 1 || NUM_EXT > MAX_EXT) begin : g_chk
    $error("unsupported source or pin count");
  end

  arb_if #(.NUM_SRC(NUM_SRC)) arb ();

  logic [REG_W-1:0] trap_ctrl_q, trap_ctrl_d;
  logic alt_table_q;
  logic disi_q;
  logic [NUM_EXT-1:0] ext_pol_q;
  logic [NUM_SRC-1:0] flag_q, flag_d;
  logic [NUM_SRC-1:0] enable_q, enable_d;
  logic [PRIO_W-1:0] prio_q [NUM_SRC];
  logic [PRIO_W-1:0] level_low_q;
  logic level_top_q;
  logic [VEC_W-1:0] pend_vec_q;
  logic [LEVEL_W-1:0] pend_level_q;
  logic [NUM_EVENTS-1:0] irq_sts_q, irq_sts_d, irq_mask_q;
  logic [NUM_EXT-1:0] ext_edge;
  logic [NUM_SRC-1:0] set_vec;
  logic core_req_q, irq_q, pready_q, pslverr_q;
  logic [DATA_W-1:0] prdata_q, rd_d;
  logic hit;
  logic acc, wr;
  logic nest_dis;

  assign nest_dis = trap_ctrl_q[NEST_DIS_BIT];

  // apb: zero wait, answer in the first access cycle
  assign acc = psel & penable & pready_q;
  assign wr = acc & pwrite;

  ext_edge_detect #(.NUM_EXT(NUM_EXT)) u_edge (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .pin(ext_pin),
    .neg_sel(ext_pol_q),
    .edge_pulse(ext_edge)
  );

  prio_arbiter #(.NUM_SRC(NUM_SRC)) u_arb (
    .a(arb.arb)
  );

  // external pins feed the lowest sources in vector order
  always_comb begin
    set_vec = src_event;
    set_vec[NUM_EXT-1:0] = src_event[NUM_EXT-1:0] | ext_edge;
  end

  assign arb.active = flag_q & enable_q;
  assign arb.prio = prio_q;
  assign arb.cpu_level = {level_top_q, level_low_q};

  // trap control: hardware trap flags win over a software clear
  always_comb begin
    trap_ctrl_d = trap_ctrl_q;
    if (wr && paddr == OFS_TRAP_CTRL) begin
      trap_ctrl_d = pwdata[REG_W-1:0] & (TRAP_STS_MASK | TRAP_EN_MASK | (16'h0001 << NEST_DIS_BIT));
    end
    trap_ctrl_d = trap_ctrl_d | (trap_event & TRAP_STS_MASK);
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      trap_ctrl_q <= REG_RST;
    end else begin
      trap_ctrl_q <= trap_ctrl_d;
    end
  end

  // global control
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      alt_table_q <= 1'b0;
      ext_pol_q <= '0;
      disi_q <= 1'b0;
    end else begin
      disi_q <= disi_active;
      if (wr && paddr == OFS_GLOBAL_CTRL) begin
        alt_table_q <= pwdata[ALT_TABLE_BIT];
        ext_pol_q <= pwdata[NUM_EXT-1:0];
      end
    end
  end

  // flags and enables, one 16-bit word per register in vector order
  always_comb begin
    flag_d = flag_q;
    enable_d = enable_q;
    for (int r = 0; r < NUM_FREG; r++) begin
      if (wr && paddr == OFS_FLAG_BASE + ADDR_W'(4 * r)) begin
        flag_d[r*FLAGS_PER_REG +: FLAGS_PER_REG] = pwdata[REG_W-1:0];
      end
      if (wr && paddr == OFS_ENABLE_BASE + ADDR_W'(4 * r)) begin
        enable_d[r*FLAGS_PER_REG +: FLAGS_PER_REG] = pwdata[REG_W-1:0];
      end
    end
    // a set in the cycle of a software clear is kept
    flag_d = flag_d | set_vec;
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      flag_q <= '0;
      enable_q <= '0;
    end else begin
      flag_q <= flag_d;
      enable_q <= enable_d;
    end
  end

  // priorities, four fields per register at a stride of four bits
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_SRC; i++) begin
        prio_q[i] <= PRIO_RST;
      end
    end else begin
      for (int p = 0; p < NUM_PREG; p++) begin
        if (wr && paddr == OFS_PRIO_BASE + ADDR_W'(4 * p)) begin
          for (int k = 0; k < PRIO_PER_REG; k++) begin
            prio_q[p*PRIO_PER_REG+k] <= pwdata[k*PRIO_STRIDE +: PRIO_W];
          end
        end
      end
    end
  end

  // cpu level low bits: accept, then return, then software
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      level_low_q <= PRIO_RST;
    end else if (core_ack && arb.valid) begin
      level_low_q <= nest_dis ? NEST_LEVEL : arb.win_prio;
    end else if (core_return) begin
      level_low_q <= restore_level[PRIO_W-1:0];
    end else if (wr && paddr == OFS_CPU_STATUS && !nest_dis) begin
      level_low_q <= pwdata[CPU_LEVEL_LSB +: PRIO_W];
    end
  end

  // top bit has no software write path so traps stay unmaskable
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      level_top_q <= 1'b0;
    end else if (core_trap_entry) begin
      level_top_q <= 1'b1;
    end else if (core_return) begin
      level_top_q <= restore_level[LEVEL_TOP_BIT];
    end
  end

  // pending register follows the winner; request tracks it
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pend_vec_q <= '0;
      pend_level_q <= '0;
      core_req_q <= 1'b0;
    end else begin
      core_req_q <= arb.valid;
      if (arb.valid) begin
        pend_vec_q <= arb.vector;
        pend_level_q <= {1'b0, arb.win_prio};
      end
    end
  end

  // sticky events, write one to clear, set wins
  always_comb begin
    irq_sts_d = irq_sts_q;
    if (wr && paddr == OFS_IRQ_STATUS) begin
      irq_sts_d = irq_sts_q & ~pwdata[NUM_EVENTS-1:0];
    end
    irq_sts_d[EV_TRAP] = irq_sts_d[EV_TRAP] | (|(trap_event & TRAP_STS_MASK));
    irq_sts_d[EV_ACCEPT] = irq_sts_d[EV_ACCEPT] | (core_ack & arb.valid);
    irq_sts_d[EV_EXT_EDGE] = irq_sts_d[EV_EXT_EDGE] | (|ext_edge);
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      irq_sts_q <= '0;
      irq_mask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      irq_sts_q <= irq_sts_d;
      if (wr && paddr == OFS_IRQ_MASK) begin
        irq_mask_q <= pwdata[NUM_EVENTS-1:0];
      end
      irq_q <= |(irq_sts_d & irq_mask_q);
    end
  end

  // read mux; unused high bits read zero
  always_comb begin
    rd_d = '0;
    hit = 1'b1;
    case (paddr)
      OFS_TRAP_CTRL: rd_d[REG_W-1:0] = trap_ctrl_q;
      OFS_GLOBAL_CTRL: begin
        rd_d[ALT_TABLE_BIT] = alt_table_q;
        rd_d[DISI_BIT] = disi_q;
        rd_d[NUM_EXT-1:0] = ext_pol_q;
      end
      OFS_CPU_STATUS: rd_d[CPU_LEVEL_LSB +: PRIO_W] = level_low_q;
      OFS_CORE_CTRL: rd_d[LEVEL_TOP_BIT] = level_top_q;
      OFS_PENDING: begin
        rd_d[VEC_W-1:0] = pend_vec_q;
        rd_d[PEND_LEVEL_LSB +: LEVEL_W] = pend_level_q;
      end
      OFS_IRQ_STATUS: rd_d[NUM_EVENTS-1:0] = irq_sts_q;
      OFS_IRQ_MASK: rd_d[NUM_EVENTS-1:0] = irq_mask_q;
      default: begin
        hit = 1'b0;
        for (int r = 0; r < NUM_FREG; r++) begin
          if (paddr == OFS_FLAG_BASE + ADDR_W'(4 * r)) begin
            rd_d[REG_W-1:0] = flag_q[r*FLAGS_PER_REG +: FLAGS_PER_REG];
            hit = 1'b1;
          end
          if (paddr == OFS_ENABLE_BASE + ADDR_W'(4 * r)) begin
            rd_d[REG_W-1:0] = enable_q[r*FLAGS_PER_REG +: FLAGS_PER_REG];
            hit = 1'b1;
          end
        end
        for (int p = 0; p < NUM_PREG; p++) begin
          if (paddr == OFS_PRIO_BASE + ADDR_W'(4 * p)) begin
            for (int k = 0; k < PRIO_PER_REG; k++) begin
              rd_d[k*PRIO_STRIDE +: PRIO_W] = prio_q[p*PRIO_PER_REG+k];
            end
            hit = 1'b1;
          end
        end
      end
    endcase
  end

  // answer prepared in the setup cycle so pready comes from a flop
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~hit;
      if (psel && !penable && !pwrite) begin
        prdata_q <= rd_d;
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign core_req = core_req_q;
  assign core_vector = pend_vec_q;
  assign core_new_level = pend_level_q;
  assign cpu_level = {level_top_q, level_low_q};
  assign alternate_table_select = alt_table_q;
  assign trap_enable = trap_ctrl_q[TRAP_EN_LSB +: 3];
  assign irq = irq_q;
endmodule // irq_priority_control_regs

// ### include/irq_pkg.sv
// constants shared by the interrupt priority control block
// assumes a 16-bit register view carried on a 32-bit apb data bus
package irq_pkg;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int ADDR_W = 8;
  localparam int VEC_W = 7;
  localparam int LEVEL_W = 4;
  localparam int PRIO_W = 3;
  localparam int FLAGS_PER_REG = 16;
  localparam int PRIO_PER_REG = 4;
  localparam int PRIO_STRIDE = 4;
  localparam int MAX_SRC = 128;
  localparam int MAX_EXT = 3;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_TRAP_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CPU_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CORE_CTRL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PENDING = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_FLAG_BASE = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_ENABLE_BASE = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_PRIO_BASE = 8'h60;

  // field positions
  localparam int NEST_DIS_BIT = 15;
  localparam logic [REG_W-1:0] TRAP_STS_MASK = 16'h78FE;
  localparam logic [REG_W-1:0] TRAP_EN_MASK = 16'h0700;
  localparam int TRAP_EN_LSB = 8;
  localparam int ALT_TABLE_BIT = 15;
  localparam int DISI_BIT = 14;
  localparam int CPU_LEVEL_LSB = 5;
  localparam int LEVEL_TOP_BIT = 3;
  localparam int PEND_LEVEL_LSB = 8;

  // values
  localparam logic [REG_W-1:0] REG_RST = 16'h0000;
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h0;
  localparam logic [PRIO_W-1:0] NEST_LEVEL = 3'h7;

  // sticky event bits
  localparam int EV_TRAP = 0;
  localparam int EV_ACCEPT = 1;
  localparam int EV_EXT_EDGE = 2;
  localparam int NUM_EVENTS = 3;
endpackage

// ### include/arb_if.sv
// request and answer bundle between the register block and the priority picker
// assumes the picker is purely combinational
`timescale 1ns/1ps
interface arb_if #(parameter int NUM_SRC = 16) ();
  import irq_pkg::*;
  logic [NUM_SRC-1:0] active;
  logic [PRIO_W-1:0] prio [NUM_SRC];
  logic [LEVEL_W-1:0] cpu_level;
  logic valid;
  logic [VEC_W-1:0] vector;
  logic [PRIO_W-1:0] win_prio;
  modport arb (input active, input prio, input cpu_level, output valid, output vector, output win_prio);
  modport ctl (output active, output prio, output cpu_level, input valid, input vector, input win_prio);
endinterface

// ### verilog/prio_arbiter.sv
// picks the winning pending source for the core
// assumes active already folds flag and enable together
`timescale 1ns/1ps
module prio_arbiter import irq_pkg::*; #(
  parameter int NUM_SRC = 16
) (
  arb_if.arb a
);
  logic [PRIO_W-1:0] best;
  logic [VEC_W-1:0] best_vec;

  // walk downward so an equal priority moves the pick to the lower vector
  always_comb begin
    best = PRIO_RST;
    best_vec = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (a.active[i] && a.prio[i] != PRIO_RST && a.prio[i] >= best) begin
        best = a.prio[i];
        best_vec = VEC_W'(i);
      end
    end
  end

  // level top bit set gives 8..15, above every 3-bit priority
  assign a.valid = (best != PRIO_RST) && ({1'b0, best} > a.cpu_level);
  assign a.vector = best_vec;
  assign a.win_prio = best;
endmodule // prio_arbiter

// ### verilog/ext_edge_detect.sv
// edge detectors for the external request pins
// assumes pins are already synchronous to sys_clk
`timescale 1ns/1ps
module ext_edge_detect #(
  parameter int NUM_EXT = 3
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [NUM_EXT-1:0] pin,
  input wire logic [NUM_EXT-1:0] neg_sel,
  output logic [NUM_EXT-1:0] edge_pulse
);
  logic [NUM_EXT-1:0] prev_q;
  logic armed_q;

  // armed keeps a pin already high at reset release from faking an edge
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prev_q <= '0;
      armed_q <= 1'b0;
    end else begin
      prev_q <= pin;
      armed_q <= 1'b1;
    end
  end

  for (genvar i = 0; i < NUM_EXT; i++) begin : g_pin
    assign edge_pulse[i] = armed_q & (neg_sel[i] ? (prev_q[i] & ~pin[i]) : (~prev_q[i] & pin[i]));
  end
endmodule // ext_edge_detect

// ### verification/irq_priority_control_regs_asserts.sv
// port-level assertions for the interrupt priority control registers
// assumes one clock, sys_clk, and a synchronous active-low rstn
`timescale 1ns/1ps
module irq_priority_control_regs_asserts import irq_pkg::*; #(
  parameter int NUM_SRC = 16,
  parameter int NUM_EXT = 3
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // sources and core
  input wire logic [NUM_SRC-1:0] src_event,
  input wire logic core_ack,
  input wire logic core_trap_entry,
  input wire logic core_return,
  input wire logic [LEVEL_W-1:0] restore_level,
  input wire logic core_req,
  input wire logic [LEVEL_W-1:0] core_new_level,
  input wire logic [LEVEL_W-1:0] cpu_level,
  input wire logic alternate_table_select,
  input wire logic [2:0] trap_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic wr_done;
  assign wr_done = psel && penable && pwrite && pready;
  // only judged when nothing moved the state in the cycle before the ack
  property p_ack;
    core_ack && core_req && !cpu_level[3] && !core_trap_entry && !$past(psel) && !$past(core_ack)
      && !$past(core_return) && $past(src_event) == '0
      |=> cpu_level[2:0] == $past(core_new_level[2:0]) || cpu_level[2:0] == NEST_LEVEL;
  endproperty
  a_pready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("pready not one cycle after setup");
  a_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_top_blocks: assert property ($past(cpu_level[3]) |-> !core_req)
    else $error("request while level top bit set");
  a_req_above: assert property (core_req |-> core_new_level > $past(cpu_level))
    else $error("request not above cpu level");
  a_ack_level: assert property (p_ack)
    else $error("accept loaded wrong level");
  a_trap_top: assert property (core_trap_entry && !core_ack && !core_return |=> cpu_level[3])
    else $error("trap entry did not set top bit");
  a_return_level: assert property (
    core_return && !core_ack && !core_trap_entry |=> cpu_level == $past(restore_level))
    else $error("return did not restore level");
  a_alt_write: assert property (
    $changed(alternate_table_select) |-> $past(wr_done && paddr == OFS_GLOBAL_CTRL))
    else $error("table select moved without write");
  a_trap_en_write: assert property ($changed(trap_enable) |-> $past(wr_done && paddr == OFS_TRAP_CTRL))
    else $error("trap enables moved without write");
  a_level_cause: assert property ($changed(cpu_level[2:0]) |->
    $past(wr_done && paddr == OFS_CPU_STATUS || core_ack || core_return))
    else $error("level bits moved without cause");
  c_accept: cover property (core_ack && core_req);
  c_refused: cover property (pslverr);
  c_top_bit: cover property (cpu_level[3] && !core_req);
endmodule // irq_priority_control_regs_asserts

bind irq_priority_control_regs irq_priority_control_regs_asserts #(.NUM_SRC(NUM_SRC), .NUM_EXT(NUM_EXT)) u_chk (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .src_event(src_event), .core_ack(core_ack),
  .core_trap_entry(core_trap_entry), .core_return(core_return), .restore_level(restore_level),
  .core_req(core_req), .core_new_level(core_new_level), .cpu_level(cpu_level),
  .alternate_table_select(alternate_table_select), .trap_enable(trap_enable));

// ### verification/irq_core_model.sv
// processor core stand-in that accepts presented requests
// assumes the bench enables it and picks how slowly it answers
`timescale 1ns/1ps
module irq_core_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // bench control
  input wire logic auto_ack,
  input wire logic [3:0] ack_delay,
  // core side
  input wire logic core_req,
  output logic core_ack
);
  logic [3:0] wait_q;
  // ack is a one-cycle pulse, so a stale request is never held acked
  always_ff @(posedge sys_clk) begin
    if (!rstn || core_ack || !auto_ack || !core_req) begin
      core_ack <= 1'b0;
      wait_q <= 4'h0;
    end else if (wait_q >= ack_delay) begin
      core_ack <= 1'b1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule // irq_core_model

// ### verification/test_irq_priority_control_regs.sv
// self-checking bench for the interrupt priority control registers
// assumes irq_pkg, arb_if, the design and the core model compile first
`timescale 1ns/1ps
`define CHK(n, x, g) begin check_count++; if ((g) !== (x)) begin mismatches++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, x, g); end end
module test_irq_priority_control_regs import irq_pkg::*; ;
  logic sys_clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [15:0] src_event = 16'h0, trap_event = 16'h0;
  logic [2:0] ext_pin = 3'h0, trap_enable;
  logic disi_active = 1'b0, core_trap_entry = 1'b0, core_return = 1'b0, auto_ack = 1'b0;
  logic [3:0] restore_level = 4'h0, ack_delay = 4'h0, core_new_level, cpu_level;
  logic pready, pslverr, core_ack, core_req, alternate_table_select, irq;
  logic [6:0] core_vector;
  logic [7:0] ofs [6] = '{OFS_TRAP_CTRL, OFS_GLOBAL_CTRL, OFS_CPU_STATUS, OFS_CORE_CTRL, OFS_PENDING, OFS_IRQ_STATUS};
  int mismatches = 0, check_count = 0;

  irq_priority_control_regs #(.NUM_SRC(16), .NUM_EXT(3)) dut (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_event(src_event),
    .ext_pin(ext_pin), .trap_event(trap_event), .disi_active(disi_active), .core_ack(core_ack),
    .core_trap_entry(core_trap_entry), .core_return(core_return), .restore_level(restore_level),
    .core_req(core_req), .core_vector(core_vector), .core_new_level(core_new_level), .cpu_level(cpu_level),
    .alternate_table_select(alternate_table_select), .trap_enable(trap_enable), .irq(irq));
  irq_core_model core (.sys_clk(sys_clk), .rstn(rstn), .auto_ack(auto_ack), .ack_delay(ack_delay),
    .core_req(core_req), .core_ack(core_ack));

  initial forever #2 sys_clk = ~sys_clk;

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // no local limit: a hung slave is ended by the watchdog
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle edge so the next setup never re-raises psel in the same step
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    bus(1'b0, a, 32'h0);
    `CHK($sformatf("reg %0h", a), x, q)
  endtask
  task automatic take_ack(input logic [3:0] dly);
    int n;
    n = 0;
    auto_ack <= 1'b1;
    ack_delay <= dly;
    while (core_ack !== 1'b1 && n < 30) begin
      @(posedge sys_clk);
      n++;
    end
    auto_ack <= 1'b0;
    if (n >= 30) mismatches++;
    tick(3);
  endtask
  task automatic pin(input logic [2:0] v, input logic [31:0] x);
    ext_pin <= v;
    tick(4);
    rd(OFS_FLAG_BASE, x);
    bus(1'b1, OFS_FLAG_BASE, 32'h0);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // the tests take well under 2000 cycles
  initial begin
    tick(20000);
    mismatches++;
    summarize();
  end

  initial begin
    tick(12);
    rstn <= 1'b1;
    tick(1);
    foreach (ofs[i]) rd(ofs[i], 32'h0);
    rd(8'hFC, 32'h0);
    `CHK("slverr", 1'b1, e)
    bus(1'b1, OFS_TRAP_CTRL, 32'h0701);
    rd(OFS_TRAP_CTRL, 32'h0700);
    `CHK("trap_enable", 3'h7, trap_enable)
    bus(1'b1, OFS_GLOBAL_CTRL, 32'hFFFF);
    // the status mirror lags its input by one cycle
    disi_active <= 1'b1;
    tick(1);
    rd(OFS_GLOBAL_CTRL, 32'hC007);
    `CHK("alt table", 1'b1, alternate_table_select)
    disi_active <= 1'b0;
    bus(1'b1, OFS_TRAP_CTRL, 32'h0);
    bus(1'b1, OFS_GLOBAL_CTRL, 32'h0);
    // rising edges count first, then falling after the polarity flip
    pin(3'h1, 32'h1);
    pin(3'h0, 32'h0);
    bus(1'b1, OFS_GLOBAL_CTRL, 32'h1);
    pin(3'h1, 32'h0);
    pin(3'h0, 32'h1);
    trap_event <= 16'h0002;
    tick(1);
    trap_event <= 16'h0;
    tick(2);
    rd(OFS_TRAP_CTRL, 32'h0002);
    rd(OFS_IRQ_STATUS, 32'h5);
    `CHK("irq masked", 1'b0, irq)
    bus(1'b1, OFS_IRQ_MASK, 32'h7);
    tick(2);
    `CHK("irq", 1'b1, irq)
    bus(1'b1, OFS_IRQ_STATUS, 32'h5);
    bus(1'b1, OFS_TRAP_CTRL, 32'h0);
    tick(2);
    `CHK("irq clear", 1'b0, irq)
    rd(OFS_TRAP_CTRL, 32'h0);
    for (int v = 0; v < 8; v++) begin
      bus(1'b1, OFS_CPU_STATUS, 32'(v) << 5);
      rd(OFS_CPU_STATUS, 32'(v) << 5);
      `CHK("cpu level", 4'(v), cpu_level)
    end
    bus(1'b1, OFS_CORE_CTRL, 32'h8);
    rd(OFS_CORE_CTRL, 32'h0);
    bus(1'b1, OFS_CPU_STATUS, 32'h60);
    bus(1'b1, OFS_TRAP_CTRL, 32'h8000);
    bus(1'b1, OFS_CPU_STATUS, 32'h20);
    rd(OFS_CPU_STATUS, 32'h60);
    bus(1'b1, OFS_TRAP_CTRL, 32'h0);
    bus(1'b1, OFS_CPU_STATUS, 32'h0);
    // sources 0 and 3 at priority 2, source 3 masked off first
    bus(1'b1, OFS_PRIO_BASE, 32'h2002);
    rd(OFS_PRIO_BASE, 32'h2002);
    bus(1'b1, OFS_ENABLE_BASE, 32'h1);
    src_event <= 16'h0009;
    tick(1);
    src_event <= 16'h0;
    rd(OFS_FLAG_BASE, 32'h9);
    bus(1'b1, OFS_PRIO_BASE, 32'h2000);
    tick(2);
    `CHK("req disabled", 1'b0, core_req)
    bus(1'b1, OFS_PRIO_BASE, 32'h2002);
    bus(1'b1, OFS_ENABLE_BASE, 32'h9);
    rd(OFS_PENDING, 32'h0200);
    `CHK("tie vector", 7'h0, core_vector)
    `CHK("new level", 4'h2, core_new_level)
    bus(1'b1, OFS_PRIO_BASE, 32'h2000);
    tick(2);
    `CHK("zero prio skipped", 7'h3, core_vector)
    `CHK("req", 1'b1, core_req)
    bus(1'b1, OFS_CPU_STATUS, 32'h40);
    tick(2);
    `CHK("equal level", 1'b0, core_req)
    bus(1'b1, OFS_CPU_STATUS, 32'h20);
    tick(2);
    take_ack(4'h3);
    `CHK("accept level", 4'h2, cpu_level)
    `CHK("irq accept", 1'b1, irq)
    rd(OFS_FLAG_BASE, 32'h9);
    rd(OFS_IRQ_STATUS, 32'h2);
    bus(1'b1, OFS_IRQ_STATUS, 32'h2);
    bus(1'b1, OFS_CPU_STATUS, 32'h0);
    bus(1'b1, OFS_TRAP_CTRL, 32'h8000);
    tick(2);
    take_ack(4'h0);
    `CHK("nest level", 4'h7, cpu_level)
    core_trap_entry <= 1'b1;
    tick(1);
    core_trap_entry <= 1'b0;
    rd(OFS_CORE_CTRL, 32'h8);
    `CHK("full level", 4'hF, cpu_level)
    restore_level <= 4'h8;
    core_return <= 1'b1;
    tick(1);
    core_return <= 1'b0;
    tick(3);
    `CHK("top blocks", 1'b0, core_req)
    restore_level <= 4'h0;
    core_return <= 1'b1;
    tick(1);
    core_return <= 1'b0;
    tick(3);
    `CHK("req back", 1'b1, core_req)
    summarize();
  end
endmodule // test_irq_priority_control_regs
